// ### logic/rpd_pkg.sv
// Shared constants and types for the reference pulse decoder.
package rpd_pkg;

   // Encoding select codes.
   localparam logic [3:0] RPD_ENC_DEFAULT = 4'h0;
   localparam logic [3:0] RPD_ENC_NEG_BASE = 4'h5;
   localparam logic [3:0] RPD_ENC_MAX = 4'h9;

   // Input filter length in clock cycles when the filter is selected.
   localparam int unsigned RPD_FILTER_CYCLES = 8;

   // Width of the commanded position counter.
   localparam int unsigned RPD_POS_WIDTH = 32;

   // Pulse forms, independent of logic polarity.
   typedef enum logic [2:0] {
      RPD_FORM_SIGN_PULSE,
      RPD_FORM_FWD_REV,
      RPD_FORM_QUAD_X1,
      RPD_FORM_QUAD_X2,
      RPD_FORM_QUAD_X4
   } rpd_form_e;

endpackage : rpd_pkg

// ### logic/rpd_line_if.sv
// Carrier for the conditioned pulse and sign line levels.
`timescale 1ns/10ps
interface rpd_line_if;
   // Bit 0 is the pulse line, bit 1 the sign line.
   logic [1:0] lvl;

   modport src (output lvl);
   modport dst (input lvl);
endinterface : rpd_line_if

// ### logic/rpd_input_cond.sv
// Synchroniser and optional glitch filter for the two reference pulse lines.
`timescale 1ns/10ps
module rpd_input_cond #(
   parameter int unsigned FILT_CYCLES = rpd_pkg::RPD_FILTER_CYCLES
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Raw pin levels and filter enable.
   input wire logic [1:0] raw_lvl,
   input wire logic filt_en,
   // Conditioned levels.
   rpd_line_if.src lines
);
   import rpd_pkg::*;

   localparam int unsigned CW = $clog2(FILT_CYCLES + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(FILT_CYCLES - 1);

   logic [1:0] sync1_q;
   logic [1:0] sync2_q;
   logic [1:0] lvl_q;
   logic [CW-1:0] cnt_q [2];

   // Two flip-flops on each pin before any logic looks at it.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= 2'h0;
         sync2_q <= 2'h0;
      end else begin
         sync1_q <= raw_lvl;
         sync2_q <= sync1_q;
      end
   end

   // A level change passes at once, or only after it has been steady for the filter length.
   // The filter trades a fixed delay for immunity to short spikes on open-collector wiring.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lvl_q <= 2'h0;
         cnt_q[0] <= '0;
         cnt_q[1] <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (sync2_q[i] != lvl_q[i]) begin
               if (!filt_en || cnt_q[i] == CNT_LAST) begin
                  lvl_q[i] <= sync2_q[i];
                  cnt_q[i] <= '0;
               end else begin
                  cnt_q[i] <= cnt_q[i] + CW'(1);
               end
            end else begin
               cnt_q[i] <= '0;
            end
         end
      end
   end

   assign lines.lvl = lvl_q;

endmodule : rpd_input_cond

// ### logic/rpd_decoder.sv
// Reference pulse decoder: turns host pulse lines into a signed commanded position.
`timescale 1ns/10ps
module rpd_decoder #(
   parameter int unsigned POS_WIDTH = rpd_pkg::RPD_POS_WIDTH,
   parameter int unsigned FILT_CYCLES = rpd_pkg::RPD_FILTER_CYCLES
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Reference pulse pins, already resolved to logic levels by the receivers.
   input wire logic reference_pulse_line,
   input wire logic reference_sign_line,
   // Configuration from the drive's parameter store, same clock domain.
   input wire logic [3:0] pulse_encoding_select,
   input wire logic pulse_input_filter_select,
   // Sequence inputs from the host connector, asynchronous.
   input wire logic servo_on,
   input wire logic error_clear,
   // Commanded position and count events.
   output logic signed [POS_WIDTH-1:0] position_q,
   output logic step_q,
   output logic dir_q
);
   import rpd_pkg::*;

   rpd_line_if lines ();

   logic [3:0] enc_q;
   logic enc_chg_q;
   logic [1:0] seq_s1_q;
   logic [1:0] seq_s2_q;
   logic a_prev_q;
   logic b_prev_q;
   logic filt_q;
   rpd_form_e form;
   logic neg;
   logic a;
   logic b;
   logic signed [2:0] delta;
   logic servo_on_s;
   logic clear_s;
   logic accept;
   logic a_rise;
   logic b_rise;
   logic a_move;
   logic b_move;

   // Splits an encoding code into its form and polarity; codes above 9 decode as quadrature x4 but are not valid.
   function automatic logic decode_valid(input logic [3:0] code);
      return code <= RPD_ENC_MAX;
   endfunction : decode_valid

   function automatic rpd_form_e decode_form(input logic [3:0] code);
      logic [3:0] base;
      base = (code >= RPD_ENC_NEG_BASE) ? code - RPD_ENC_NEG_BASE : code;
      case (base)
         4'h0: return RPD_FORM_SIGN_PULSE;
         4'h1: return RPD_FORM_FWD_REV;
         4'h2: return RPD_FORM_QUAD_X1;
         4'h3: return RPD_FORM_QUAD_X2;
         default: return RPD_FORM_QUAD_X4;
      endcase
   endfunction : decode_form

   // Rising edge of a conditioned line against its level one cycle earlier.
   function automatic logic rose(input logic cur, input logic prev);
      return cur && !prev;
   endfunction : rose

   // Any change of a conditioned line against its level one cycle earlier.
   function automatic logic moved(input logic cur, input logic prev);
      return cur != prev;
   endfunction : moved

   // One signed count, forward when the argument is high.
   function automatic logic signed [2:0] unit_step(input logic fwd);
      return fwd ? 3'sd1 : -3'sd1;
   endfunction : unit_step

   // Pin conditioning for both lines. With the filter off a pin edge reaches the position and step
   // registers on the fourth clock edge, counting the one that first samples it.
   rpd_input_cond #(
      .FILT_CYCLES(FILT_CYCLES)
   ) u_cond (
      .clk(clk),
      .nrst(nrst),
      .raw_lvl({reference_sign_line, reference_pulse_line}),
      .filt_en(filt_q),
      .lines(lines.src)
   );

   // Configuration is latched so that a change is seen one cycle late and can be masked.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         enc_q <= RPD_ENC_DEFAULT;
         enc_chg_q <= 1'b0;
         filt_q <= 1'b0;
      end else begin
         enc_q <= pulse_encoding_select;
         enc_chg_q <= (pulse_encoding_select != enc_q);
         filt_q <= pulse_input_filter_select;
      end
   end

   // Servo on and error clear come from the connector and are synchronised.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         seq_s1_q <= 2'h0;
         seq_s2_q <= 2'h0;
      end else begin
         seq_s1_q <= {error_clear, servo_on};
         seq_s2_q <= seq_s1_q;
      end
   end

   // Polarity: negative logic inverts both lines before any edge is judged.
   always_comb begin
      form = decode_form(enc_q);
      neg = (enc_q >= RPD_ENC_NEG_BASE);
      a = lines.lvl[0] ^ neg;
      b = lines.lvl[1] ^ neg;
   end

   // Synchronised sequence levels under their own names.
   assign servo_on_s = seq_s2_q[0];
   assign clear_s = seq_s2_q[1];

   // Edge flags of both polarity-adjusted lines against the previous cycle.
   always_comb begin
      a_rise = rose(a, a_prev_q);
      b_rise = rose(b, b_prev_q);
      a_move = moved(a, a_prev_q);
      b_move = moved(b, b_prev_q);
   end

   // Counts pass only with servo on, a defined code and no code change in the last cycle.
   // Masking the changeover cycle may lose one count, which is cheaper than a false polarity edge.
   always_comb begin
      accept = servo_on_s && decode_valid(enc_q) && !enc_chg_q;
   end

   // Per-cycle count change; a lead of the pulse line over the sign line is forward.
   always_comb begin
      delta = 3'sd0;
      case (form)
         RPD_FORM_SIGN_PULSE: begin
            if (a_rise) begin
               delta = unit_step(b);
            end
         end
         RPD_FORM_FWD_REV: begin
            // Simultaneous edges on both lines cancel out.
            delta = (a_rise ? 3'sd1 : 3'sd0) - (b_rise ? 3'sd1 : 3'sd0);
         end
         RPD_FORM_QUAD_X1: begin
            if (a_rise && !b_move) begin
               delta = unit_step(!b);
            end
         end
         RPD_FORM_QUAD_X2, RPD_FORM_QUAD_X4: begin
            // Both phases changing at once is an illegal quadrature step and is dropped.
            if (a_move && !b_move) begin
               delta = unit_step(a != b);
            end else if (b_move && !a_move && form == RPD_FORM_QUAD_X4) begin
               delta = unit_step(a == b);
            end
         end
         default: delta = 3'sd0;
      endcase
      // Pulses before servo on, on an undefined code, or across a code change are not accepted.
      if (!accept) begin
         delta = 3'sd0;
      end
   end

   // Previous levels, always tracked so that enabling counting never produces a false edge.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         a_prev_q <= 1'b0;
         b_prev_q <= 1'b0;
      end else begin
         a_prev_q <= a;
         b_prev_q <= b;
      end
   end

   // Commanded position: moves only by accepted counts; held at zero while clear is asserted.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         position_q <= '0;
      end else if (clear_s) begin
         position_q <= '0;
      end else begin
         position_q <= position_q + POS_WIDTH'(delta);
      end
   end

   // Count event outputs for the position loop.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         step_q <= 1'b0;
         dir_q <= 1'b0;
      end else begin
         step_q <= (delta != 3'sd0) && !clear_s;
         // A count refused by an active clear must not move the reported direction either.
         if ((delta != 3'sd0) && !clear_s) begin
            dir_q <= (delta > 3'sd0);
         end
      end
   end

endmodule : rpd_decoder

// ### tb/rpd_host_model.sv
// Host motion controller model driving the two reference pulse pins.
`timescale 1ns/10ps
module rpd_host_model (
   // Pacing clock.
   input wire logic clk,
   // Pin levels, a conducting output transistor reads high.
   output logic pls,
   output logic sgn
);
   logic inv = 1'b0;
   logic p = 1'b0;
   logic s = 1'b0;
   logic [3:0] a = 4'h3;
   logic [3:0] b = 4'h6;
   // Negative logic flips both pins, so the decoder sees the same sense.
   assign pls = p ^ inv;
   assign sgn = s ^ inv;
   // Pins move just after an edge and rest long enough to be seen once.
   task automatic put(input logic np, input logic ns, input int gap);
      @(posedge clk);
      #1;
      p = np;
      s = ns;
      repeat (gap - 1) @(posedge clk);
   endtask : put
   // Sends n units of one form; the sign settles before the first pulse.
   task automatic send(input int form, input int n, input logic fwd, input int gap);
      if (form == 0) put(1'b0, fwd, gap);
      repeat (n) begin
         if (form == 0) begin
            put(1'b1, fwd, gap);
            put(1'b0, fwd, gap);
         end else if (form == 1) begin
            put(fwd, !fwd, gap);
            put(1'b0, 1'b0, gap);
         end else begin
            // Forward has the pulse line a quarter period ahead.
            for (int i = 0; i < 4; i++) put(fwd ? a[i] : b[i], fwd ? b[i] : a[i], gap);
         end
      end
   endtask : send
endmodule : rpd_host_model

// ### tb/rpd_decoder_chk.sv
// Port checker for the reference pulse decoder.
`timescale 1ns/10ps
module rpd_decoder_chk #(
   parameter int unsigned POS_WIDTH = rpd_pkg::RPD_POS_WIDTH
) (
   // Clock, reset and pins.
   input wire logic clk,
   input wire logic nrst,
   input wire logic reference_pulse_line,
   input wire logic reference_sign_line,
   // Settings and host inputs.
   input wire logic [3:0] pulse_encoding_select,
   input wire logic pulse_input_filter_select,
   input wire logic servo_on,
   input wire logic error_clear,
   // Outputs.
   input wire logic signed [POS_WIDTH-1:0] position_q,
   input wire logic step_q,
   input wire logic dir_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // Six quiet edges flush the pin path, so no count may still be due.
   sequence s_quiet;
      (!pulse_input_filter_select && $stable(reference_pulse_line) && $stable(reference_sign_line)) [*6];
   endsequence
   sequence s_fwd_sign;
      (pulse_encoding_select == rpd_pkg::RPD_ENC_DEFAULT && reference_sign_line
         || pulse_encoding_select == rpd_pkg::RPD_ENC_NEG_BASE && !reference_sign_line) [*6];
   endsequence
   property p_quiet; s_quiet |-> !step_q; endproperty
   a_quiet: assert property (p_quiet) else $error("count without edge");
   property p_sign; s_fwd_sign ##1 step_q |-> dir_q; endproperty
   a_sign: assert property (p_sign) else $error("sign sense wrong");
   property p_unit; step_q |-> position_q == $past(position_q) + (dir_q ? 1 : -1); endproperty
   a_unit: assert property (p_unit) else $error("step size wrong");
   property p_hold; !step_q && position_q != 0 |-> $stable(position_q); endproperty
   a_hold: assert property (p_hold) else $error("moved without step");
   property p_dir; !step_q |-> $stable(dir_q); endproperty
   a_dir: assert property (p_dir) else $error("direction moved");
   property p_clear; error_clear [*3] |=> position_q == 0; endproperty
   a_clear: assert property (p_clear) else $error("clear ignored");
   property p_servo; !servo_on [*3] |=> !step_q; endproperty
   a_servo: assert property (p_servo) else $error("count with servo off");
   property p_code; (pulse_encoding_select > rpd_pkg::RPD_ENC_MAX) [*2] |=> !step_q; endproperty
   a_code: assert property (p_code) else $error("count on bad code");
endmodule : rpd_decoder_chk
bind rpd_decoder rpd_decoder_chk #(.POS_WIDTH(POS_WIDTH)) u_rpd_decoder_chk (.clk(clk), .nrst(nrst),
   .reference_pulse_line(reference_pulse_line), .reference_sign_line(reference_sign_line),
   .pulse_encoding_select(pulse_encoding_select), .pulse_input_filter_select(pulse_input_filter_select),
   .servo_on(servo_on), .error_clear(error_clear), .position_q(position_q), .step_q(step_q), .dir_q(dir_q));

// ### tb/testbench.sv
// Self-checking bench for the reference pulse decoder.
`timescale 1ns/10ps
module testbench;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [3:0] enc = 4'h0;
   logic filt = 1'b0;
   logic son = 1'b0;
   logic clr = 1'b0;
   logic pls, sgn, step_q, dir_q;
   logic signed [31:0] position_q, base;
   int fails = 0;
   int checked = 0;
   int cycles = 0;
   int steps = 0;
   rpd_decoder #(.FILT_CYCLES(2)) u_rpd_decoder (.clk(clk), .nrst(nrst), .reference_pulse_line(pls),
      .reference_sign_line(sgn), .pulse_encoding_select(enc), .pulse_input_filter_select(filt),
      .servo_on(son), .error_clear(clr), .position_q(position_q), .step_q(step_q), .dir_q(dir_q));
   rpd_host_model u_rpd_host_model (.clk(clk), .pls(pls), .sgn(sgn));
   // Clock, a count of reported steps, and a ceiling well above the cycles the tests need.
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (step_q === 1'b1) steps <= steps + 1;
      if (cycles == 12000) begin
         fails++;
         close_out();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out
   // Settings change off the edge; the host waits a shortened servo-on delay.
   task automatic mode(input int c, input logic f, input logic s);
      @(posedge clk);
      #1;
      enc = 4'(c);
      filt = f;
      son = s;
      u_rpd_host_model.inv = c > 4 && c < 10;
      repeat (6) @(posedge clk);
   endtask : mode
   task automatic run(input int form, input int n, input logic fwd, input int gap, input int exp);
      int sbase;
      base = position_q;
      sbase = steps;
      u_rpd_host_model.send(form, n, fwd, gap);
      repeat (8) @(posedge clk);
      #1;
      check(position_q - base, 32'(exp));
      check(32'(steps - sbase), 32'(exp < 0 ? -exp : exp));
      if (exp != 0) check({31'h0, dir_q}, {31'h0, exp > 0});
   endtask : run
   task automatic t_forms();
      int m;
      for (int c = 0; c < 10; c++) begin
         m = c % 5 < 2 ? 1 : 1 << (c % 5 - 2);
         mode(c, 1'b0, 1'b1);
         run(c % 5, 3, 1'b1, 4, 3 * m);
         run(c % 5, 2, 1'b0, 4, -2 * m);
      end
      $display("forms test done");
   endtask : t_forms
   task automatic t_refused();
      mode(0, 1'b0, 1'b0);
      run(0, 2, 1'b1, 4, 0);
      mode(12, 1'b0, 1'b1);
      run(0, 2, 1'b1, 4, 0);
      $display("refused test done");
   endtask : t_refused
   task automatic t_clear();
      mode(0, 1'b0, 1'b1);
      run(0, 2, 1'b1, 4, 2);
      clr = 1'b1;
      repeat (4000) @(posedge clk);
      #1;
      check(position_q, 32'h0);
      clr = 1'b0;
      run(0, 1, 1'b1, 4, 1);
      $display("clear test done");
   endtask : t_clear
   // A one-cycle spike must be dropped while steady pulses still count.
   task automatic t_filter();
      mode(0, 1'b1, 1'b1);
      base = position_q;
      u_rpd_host_model.put(1'b1, 1'b1, 1);
      u_rpd_host_model.put(1'b0, 1'b1, 10);
      check(position_q - base, 32'h0);
      run(0, 2, 1'b1, 6, 2);
      $display("filter test done");
   endtask : t_filter
   initial begin
      repeat (10) @(posedge clk);
      #1;
      nrst = 1'b1;
      check(position_q, 32'h0);
      check({30'h0, step_q, dir_q}, 32'h0);
      t_forms();
      t_refused();
      t_clear();
      t_filter();
      close_out();
   end
endmodule : testbench
